// ---- hw/lsr_top.sv ----
// routing registers with apb slave and signal muxes
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "lsr_regs.svh"
module lsr_top #(
  parameter int W  = 14,
  parameter int PW = 18
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            ce,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [3:0]      gen_trigger,
  input  wire logic [4*PW-1:0] gen_period,
  input  wire logic [3*W-1:0]  fe_setpoint,
  input  wire logic [3*W-1:0]  fe_data,
  input  wire logic [3*W-1:0]  filt_out,
  input  wire logic [W-1:0]    cp_out,
  output logic      [2:0]      fe_trigger,
  output logic      [3*W-1:0]  dac_setpoint,
  output logic      [3*W-1:0]  filt_input,
  output logic      [3*PW-1:0] filt_period,
  output logic      [3*W-1:0]  filt_feedforward,
  output lsr_pkg::lsr_sub_t    filt_substitute [3]
);
  import lsr_pkg::*;

  //----------------------------------------------------------
  // registers
  //----------------------------------------------------------
  logic [31:0] sample_trigger_routing, next_trig;
  logic [31:0] dac_setpoint_source,    next_dac;
  logic [31:0] filter_input_routing,   next_fmux;
  logic [31:0] period_substitute_a,    next_suba;
  logic [31:0] period_substitute_b,    next_subb;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // address decode used by read and write paths
  function automatic logic [2:0] decode(input logic [31:0] a);
    unique case (a)
      `LSR_OFS_TRIG: decode = 3'h1;
      `LSR_OFS_DAC:  decode = 3'h2;
      `LSR_OFS_FMUX: decode = 3'h3;
      `LSR_OFS_SUBA: decode = 3'h4;
      `LSR_OFS_SUBB: decode = 3'h5;
      default:       decode = 3'h0;
    endcase
  endfunction

  logic       access;
  logic [2:0] hit;
  assign access = psel && penable;
  assign hit    = decode(paddr);
  assign pready = 1'b1; // zero wait states

  // writes masked so reserved bits stay zero
  always_comb begin
    next_trig    = sample_trigger_routing;
    next_dac     = dac_setpoint_source;
    next_fmux    = filter_input_routing;
    next_suba    = period_substitute_a;
    next_subb    = period_substitute_b;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pslverr = (hit == 3'h0);
      unique case (hit)
        3'h1: next_prdata = sample_trigger_routing;
        3'h2: next_prdata = dac_setpoint_source;
        3'h3: next_prdata = filter_input_routing;
        3'h4: next_prdata = period_substitute_a;
        3'h5: next_prdata = period_substitute_b;
        default: next_prdata = 32'h0000_0000;
      endcase
      if (pwrite) next_prdata = 32'h0000_0000;
    end
    if (access) next_pslverr = pslverr;
    if (access && pwrite) begin
      unique case (hit)
        3'h1: next_trig = pwdata & `LSR_TRIG_MASK; // R01 R14
        3'h2: next_dac  = pwdata & `LSR_DAC_MASK;  // R14
        3'h3: next_fmux = pwdata & `LSR_FMUX_MASK; // R14
        3'h4: next_suba = pwdata & `LSR_SUBA_MASK; // R13 R14
        3'h5: next_subb = pwdata & `LSR_SUBB_MASK; // R13 R14
        default: ;
      endcase
    end
  end

  // register state, frozen while ce is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_trigger_routing <= `LSR_TRIG_RST; // R02
      dac_setpoint_source    <= `LSR_DAC_RST;  // R03
      filter_input_routing   <= `LSR_FMUX_RST; // R07 R11 R12
      period_substitute_a    <= `LSR_SUBA_RST; // R13
      period_substitute_b    <= `LSR_SUBB_RST;
      prdata                 <= 32'h0000_0000;
      pslverr                <= 1'b0;
    end else if (ce) begin
      sample_trigger_routing <= next_trig;
      dac_setpoint_source    <= next_dac;
      filter_input_routing   <= next_fmux;
      period_substitute_a    <= next_suba;
      period_substitute_b    <= next_subb;
      prdata                 <= next_prdata;
      pslverr                <= next_pslverr;
    end
  end

  //----------------------------------------------------------
  // routing
  //----------------------------------------------------------
  lsr_sub_t sub [3];
  assign sub[0] = period_substitute_a[13:0];
  assign sub[1] = period_substitute_a[`LSR_SUB1_POS +: 14];
  assign sub[2] = period_substitute_b[13:0];

  logic [W-1:0] fe_sp [3];
  logic [W-1:0] fo    [3];
  logic [W-1:0] sel_sp[3];
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      assign fe_sp[i] = fe_setpoint[i*W +: W];
      assign fo[i]    = filt_out[i*W +: W];
      // trigger gating per front end
      assign fe_trigger[i] =
        |(gen_trigger & sample_trigger_routing[4*i +: 4]); // R01 R02
      lsr_dac_mux #(.W(W), .SELF(i)) u_dac (
        .sel     (dac_setpoint_source[`LSR_DAC_SEL_POS+8*i +: 3]),
        .dac_sp0 (fe_sp[0]),
        .dac_sp1 (fe_sp[1]),
        .dac_sp2 (fe_sp[2]),
        .cp_out  (cp_out),
        .filt0   (fo[0]),
        .filt1   (fo[1]),
        .filt2   (fo[2]),
        .sp      (sel_sp[i])
      );
      // override bit picks the selector
      assign dac_setpoint[i*W +: W] =
        dac_setpoint_source[`LSR_DAC_EN_POS+i] ? sel_sp[i] : fe_sp[i]; // R03
      // front end data into filter, code 3 gives zero
      assign filt_input[i*W +: W] =
        (filter_input_routing[2*i +: 2] == 2'h3) ? '0 :
        fe_data[filter_input_routing[2*i +: 2]*W +: W]; // R12
      assign filt_period[i*PW +: PW] =
        gen_period[filter_input_routing[`LSR_PER_SEL_POS+2*i +: 2]*PW
                   +: PW]; // R11
      assign filt_substitute[i] =
        (filter_input_routing[`LSR_SUB_SEL_POS+2*i +: 2] == 2'h3) ? '0 :
        sub[filter_input_routing[`LSR_SUB_SEL_POS+2*i +: 2]]; // R07
    end
  endgenerate

  // feedforward: each filter picks one of the other two
  assign filt_feedforward[0*W +: W] =
    filter_input_routing[`LSR_FFWD_POS]   ? fo[2] : fo[1]; // R10
  assign filt_feedforward[1*W +: W] =
    filter_input_routing[`LSR_FFWD_POS+1] ? fo[2] : fo[0]; // R09
  assign filt_feedforward[2*W +: W] =
    filter_input_routing[`LSR_FFWD_POS+2] ? fo[1] : fo[0]; // R08

  //----------------------------------------------------------
  // checks
  //----------------------------------------------------------
  a_trig_gate: assert property (@(posedge clk) disable iff (!rstn) // R02
    fe_trigger[2] == |(gen_trigger & sample_trigger_routing[11:8]))
    else $error("trigger gating wrong");
  a_trig_reset: assert property (@(posedge clk) // R01
    $rose(rstn) |-> fe_trigger == 3'b000)
    else $error("trigger passed after reset");
  a_dac_fe: assert property (@(posedge clk) disable iff (!rstn) // R03
    !dac_setpoint_source[0] |-> dac_setpoint[W-1:0] == fe_sp[0])
    else $error("dac0 not from front end");
  a_dac2_source_select: assert property (@(posedge clk) disable iff (!rstn) // R04
    (dac_setpoint_source[2] && dac_setpoint_source[26:24] == 3'h1)
      |-> dac_setpoint[2*W +: W] == fe_sp[1])
    else $error("dac2 selector wrong");
  a_dac1_source_select: assert property (@(posedge clk) disable iff (!rstn) // R05
    (dac_setpoint_source[1] && dac_setpoint_source[18:16] == 3'h6)
      |-> dac_setpoint[W +: W] == fo[2])
    else $error("dac1 selector wrong");
  a_dac0_source_select: assert property (@(posedge clk) disable iff (!rstn) // R06
    (dac_setpoint_source[0] && dac_setpoint_source[10:8] == 3'h3)
      |-> dac_setpoint[W-1:0] == cp_out)
    else $error("dac0 selector wrong");
  a_ffwd_two: assert property (@(posedge clk) disable iff (!rstn) // R08
    filter_input_routing[18] |-> filt_feedforward[2*W +: W] == fo[1])
    else $error("filter2 feedforward wrong");
  a_ffwd_one: assert property (@(posedge clk) disable iff (!rstn) // R09
    !filter_input_routing[17] |-> filt_feedforward[W +: W] == fo[0])
    else $error("filter1 feedforward wrong");
  a_ffwd_zero: assert property (@(posedge clk) disable iff (!rstn) // R10
    !filter_input_routing[16] |-> filt_feedforward[W-1:0] == fo[1])
    else $error("filter0 feedforward wrong");
  a_fmux_reset: assert property (@(posedge clk) // R12
    $rose(rstn) |-> filter_input_routing == 32'h0000_0024)
    else $error("filter routing reset wrong");
  a_per_sel: assert property (@(posedge clk) disable iff (!rstn) // R11
    filter_input_routing[9:8] == 2'h3 |-> filt_period[PW-1:0] ==
      gen_period[3*PW +: PW])
    else $error("filter0 period source wrong");
  a_sub_sel: assert property (@(posedge clk) disable iff (!rstn) // R07
    filter_input_routing[29:28] == 2'h2 |-> filt_substitute[2] == sub[2])
    else $error("filter2 substitute wrong");
  a_sub_reset: assert property (@(posedge clk) // R13
    $rose(rstn) |-> period_substitute_a == 32'h0000_007d)
    else $error("substitute reset wrong");
  a_resv_zero: assert property (@(posedge clk) disable iff (!rstn) // R14
    (period_substitute_b[31:14] == '0) && (dac_setpoint_source[7:3] == '0))
    else $error("reserved bits set");
  a_write_lands: assert property (@(posedge clk) disable iff (!rstn) // R01
    (ce && access && pwrite && paddr == `LSR_OFS_TRIG)
      |=> sample_trigger_routing == ($past(pwdata) & 32'h0000_0fff))
    else $error("trigger write lost");
  // trigger gating: blocked unit, single enable, top enable, reserved bits
  a_trig_block: assert property (@(posedge clk) disable iff (!rstn) // R02
    (sample_trigger_routing[3:0] == 4'h0) |-> !fe_trigger[0])
    else $error("trigger passed while blocked");
  a_trig_pass: assert property (@(posedge clk) disable iff (!rstn) // R01
    (sample_trigger_routing[4] && gen_trigger[0]) |-> fe_trigger[1])
    else $error("enabled trigger not passed");
  a_trig_top: assert property (@(posedge clk) disable iff (!rstn) // R01
    (sample_trigger_routing[11] && gen_trigger[3]) |-> fe_trigger[2])
    else $error("top trigger enable not passed");
  a_resv_trig: assert property (@(posedge clk) disable iff (!rstn) // R14
    sample_trigger_routing[31:12] == 20'h0_0000)
    else $error("trigger reserved bits set");
  // setpoint selection, one case per kind of selector code
  a_dac2_fe: assert property (@(posedge clk) disable iff (!rstn) // R03
    !dac_setpoint_source[2] |-> dac_setpoint[2*W +: W] == fe_sp[2])
    else $error("dac2 not from front end");
  a_dac2_cp: assert property (@(posedge clk) disable iff (!rstn) // R04
    (dac_setpoint_source[2] && dac_setpoint_source[26:24] == 3'h3)
      |-> dac_setpoint[2*W +: W] == cp_out)
    else $error("dac2 power source wrong");
  a_dac2_undef: assert property (@(posedge clk) disable iff (!rstn) // R04
    (dac_setpoint_source[2] && dac_setpoint_source[26:24] == 3'h2)
      |-> dac_setpoint[2*W +: W] == '0)
    else $error("dac2 undefined code not zero");
  a_dac2_filt: assert property (@(posedge clk) disable iff (!rstn) // R04
    (dac_setpoint_source[2] && dac_setpoint_source[26:24] == 3'h5)
      |-> dac_setpoint[2*W +: W] == fo[1])
    else $error("dac2 filter source wrong");
  a_dac1_zero: assert property (@(posedge clk) disable iff (!rstn) // R05
    (dac_setpoint_source[1] && dac_setpoint_source[18:16] == 3'h0)
      |-> dac_setpoint[W +: W] == fe_sp[0])
    else $error("dac1 first setpoint source wrong");
  a_dac1_two: assert property (@(posedge clk) disable iff (!rstn) // R05
    (dac_setpoint_source[1] && dac_setpoint_source[18:16] == 3'h2)
      |-> dac_setpoint[W +: W] == fe_sp[2])
    else $error("dac1 third setpoint source wrong");
  a_dac1_filt: assert property (@(posedge clk) disable iff (!rstn) // R05
    (dac_setpoint_source[1] && dac_setpoint_source[18:16] == 3'h4)
      |-> dac_setpoint[W +: W] == fo[0])
    else $error("dac1 filter source wrong");
  a_dac0_one: assert property (@(posedge clk) disable iff (!rstn) // R06
    (dac_setpoint_source[0] && dac_setpoint_source[10:8] == 3'h1)
      |-> dac_setpoint[W-1:0] == fe_sp[1])
    else $error("dac0 second setpoint source wrong");
  a_dac0_filt: assert property (@(posedge clk) disable iff (!rstn) // R06
    (dac_setpoint_source[0] && dac_setpoint_source[10:8] == 3'h6)
      |-> dac_setpoint[W-1:0] == fo[2])
    else $error("dac0 filter source wrong");
  // filter routing: other feedforward polarity, inputs, periods, constants
  a_ffwd_two_lo: assert property (@(posedge clk) disable iff (!rstn) // R08
    !filter_input_routing[18] |-> filt_feedforward[2*W +: W] == fo[0])
    else $error("filter2 default feedforward wrong");
  a_ffwd_one_hi: assert property (@(posedge clk) disable iff (!rstn) // R09
    filter_input_routing[17] |-> filt_feedforward[W +: W] == fo[2])
    else $error("filter1 alternate feedforward wrong");
  a_ffwd_zero_hi: assert property (@(posedge clk) disable iff (!rstn) // R10
    filter_input_routing[16] |-> filt_feedforward[W-1:0] == fo[2])
    else $error("filter0 alternate feedforward wrong");
  a_fe_zero: assert property (@(posedge clk) disable iff (!rstn) // R12
    (filter_input_routing[1:0] == 2'h2)
      |-> filt_input[W-1:0] == fe_data[2*W +: W])
    else $error("filter0 input source wrong");
  a_fe_one: assert property (@(posedge clk) disable iff (!rstn) // R12
    (filter_input_routing[3:2] == 2'h3)
      |-> filt_input[W +: W] == '0)
    else $error("filter1 unused input code not zero");
  a_fe_two: assert property (@(posedge clk) disable iff (!rstn) // R12
    (filter_input_routing[5:4] == 2'h0)
      |-> filt_input[2*W +: W] == fe_data[W-1:0])
    else $error("filter2 input source wrong");
  a_per_one: assert property (@(posedge clk) disable iff (!rstn) // R11
    (filter_input_routing[11:10] == 2'h2)
      |-> filt_period[PW +: PW] == gen_period[2*PW +: PW])
    else $error("filter1 period source wrong");
  a_per_two: assert property (@(posedge clk) disable iff (!rstn) // R11
    (filter_input_routing[13:12] == 2'h1)
      |-> filt_period[2*PW +: PW] == gen_period[PW +: PW])
    else $error("filter2 period source wrong");
  a_sub_one: assert property (@(posedge clk) disable iff (!rstn) // R07
    (filter_input_routing[25:24] == 2'h1)
      |-> filt_substitute[0] == period_substitute_a[29:16])
    else $error("filter0 substitute wrong");
  a_resv_fmux: assert property (@(posedge clk) disable iff (!rstn) // R14
    (filter_input_routing & ~`LSR_FMUX_MASK) == 32'h0000_0000)
    else $error("filter routing reserved bits set");
  // read path: the register lands in prdata at the setup edge
  a_read_fmux: assert property (@(posedge clk) disable iff (!rstn) // R14
    (ce && psel && !penable && !pwrite && hit == 3'h3)
      |=> prdata == $past(filter_input_routing))
    else $error("filter routing read data wrong");
endmodule // lsr_top

// ---- hw/lsr_regs.svh ----
// offsets, field positions, reset values and masks of the routing block
// Notes on behaviour
// R01: twelve trigger enables, bit 4*unit+generator
// R02: enable one passes trigger, zero blocks it
// R03: dac override bit picks selector over front end
// R04: dac2 selector codes 0,1,3,4,5,6
// R05: dac1 selector codes 0,2,3,4,5,6
// R06: dac0 selector codes 1,2,3,4,5,6
// R07: two-bit substitute select per filter, reset zero
// R08: filter2 feedforward: filter0 or filter1
// R09: filter1 feedforward: filter0 or filter2
// R10: filter0 feedforward: filter1 or filter2
// R11: two-bit period source per filter, reset gen0
// R12: front end select per filter, reset same number
// R13: three 14-bit substitutes, constant 0 resets 0x7d
// R14: reserved bits read zero, ignore writes
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH
`define LSR_OFS_TRIG     32'h0012_000c
`define LSR_OFS_DAC      32'h0012_0010
`define LSR_OFS_FMUX     32'h0012_0014
`define LSR_OFS_SUBA     32'h0012_0018
`define LSR_OFS_SUBB     32'h0012_001c
`define LSR_TRIG_MASK    32'h0000_0fff
`define LSR_DAC_MASK     32'h0707_0707
`define LSR_FMUX_MASK    32'h3f07_3f3f
`define LSR_SUBA_MASK    32'h3fff_3fff
`define LSR_SUBB_MASK    32'h0000_3fff
`define LSR_TRIG_RST     32'h0000_0000
`define LSR_DAC_RST      32'h0000_0000
`define LSR_FMUX_RST     32'h0000_0024
`define LSR_SUBA_RST     32'h0000_007d
`define LSR_SUBB_RST     32'h0000_0000
`define LSR_DAC_EN_POS   0
`define LSR_DAC_SEL_POS  8
`define LSR_DAC_SEL_STEP 8
`define LSR_FE_SEL_POS   0
`define LSR_PER_SEL_POS  8
`define LSR_FFWD_POS     16
`define LSR_SUB_SEL_POS  24
`define LSR_SUB1_POS     16
`endif

// ---- hw/lsr_pkg.sv ----
// types shared by the routing block
package lsr_pkg;
  typedef logic [2:0]  lsr_dac_sel_t;
  typedef logic [1:0]  lsr_sel2_t;
  typedef logic [13:0] lsr_sub_t;
  typedef enum logic [6:0] {
    LSR_SRC_DAC0 = 7'h01,
    LSR_SRC_DAC1 = 7'h02,
    LSR_SRC_DAC2 = 7'h04,
    LSR_SRC_CP   = 7'h08,
    LSR_SRC_F0   = 7'h10,
    LSR_SRC_F1   = 7'h20,
    LSR_SRC_F2   = 7'h40
  } lsr_src_t;
endpackage

// ---- hw/lsr_dac_mux.sv ----
// setpoint selector for one dac in override mode
`timescale 1ns/1ps
module lsr_dac_mux #(
  parameter int W    = 14,
  parameter int SELF = 0
) (
  input  wire logic [2:0]   sel,
  input  wire logic [W-1:0] dac_sp0,
  input  wire logic [W-1:0] dac_sp1,
  input  wire logic [W-1:0] dac_sp2,
  input  wire logic [W-1:0] cp_out,
  input  wire logic [W-1:0] filt0,
  input  wire logic [W-1:0] filt1,
  input  wire logic [W-1:0] filt2,
  output logic      [W-1:0] sp
);
  import lsr_pkg::*;
  // undefined codes and the dac's own index give zero
  always_comb begin
    unique case (sel)
      3'h0: sp = (SELF == 0) ? '0 : dac_sp0; // R04 R05 R06
      3'h1: sp = (SELF == 1) ? '0 : dac_sp1;
      3'h2: sp = (SELF == 2) ? '0 : dac_sp2;
      3'h3: sp = cp_out;
      3'h4: sp = filt0;
      3'h5: sp = filt1;
      3'h6: sp = filt2;
      default: sp = '0;
    endcase
  end
endmodule // lsr_dac_mux

// ---- sim/lsr_far_model.sv ----
// far side model: pwm generators, front ends, filters, constant power
`timescale 1ns/1ps
module lsr_far_model #(
  parameter int W  = 14,
  parameter int PW = 18
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  output logic      [3:0]      gen_trigger,
  output logic      [4*PW-1:0] gen_period,
  output logic      [3*W-1:0]  fe_setpoint,
  output logic      [3*W-1:0]  fe_data,
  output logic      [3*W-1:0]  filt_out,
  output logic      [W-1:0]    cp_out
);
  logic [255:0] pool;
  logic [255:0] next_pool;
  logic [31:0]  word;
  // fresh word every cycle so a stale or wrong route shows at once
  always_comb begin
    word      = pool[31:0] ^ (pool[31:0] << 13);
    word      = word ^ (word >> 17);
    word      = word ^ (word << 5);
    next_pool = {pool[223:0], word};
  end
  // pool register, nonzero after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pool <= {8{32'h1357_9bdf}};
    end else begin
      pool <= next_pool;
    end
  end
  // slices of the pool feed every far side value
  assign gen_trigger = pool[3:0];
  assign gen_period  = pool[75:4];
  assign fe_setpoint = pool[117:76];
  assign fe_data     = pool[159:118];
  assign filt_out    = pool[201:160];
  assign cp_out      = pool[215:202];
endmodule // lsr_far_model

// ---- sim/loop_signal_routing_mux_bench.sv ----
// self-checking bench for the routing registers and muxes
`timescale 1ns/1ps
`include "lsr_regs.svh"
module loop_signal_routing_mux_bench;
  import lsr_pkg::*;
  localparam int W  = 14;
  localparam int PW = 18;
  localparam logic [31:0] OFS [5] = '{`LSR_OFS_TRIG, `LSR_OFS_DAC,
    `LSR_OFS_FMUX, `LSR_OFS_SUBA, `LSR_OFS_SUBB};
  localparam logic [31:0] MSK [5] = '{`LSR_TRIG_MASK, `LSR_DAC_MASK,
    `LSR_FMUX_MASK, `LSR_SUBA_MASK, `LSR_SUBB_MASK};
  localparam logic [31:0] RST [5] = '{`LSR_TRIG_RST, `LSR_DAC_RST,
    `LSR_FMUX_RST, `LSR_SUBA_RST, `LSR_SUBB_RST};
  logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, q, seed;
  logic [3:0] gen_trigger;
  logic [2:0] fe_trigger;
  logic [4*PW-1:0] gen_period;
  logic [3*PW-1:0] filt_period;
  logic [3*W-1:0] fe_setpoint, fe_data, filt_out, dac_setpoint;
  logic [3*W-1:0] filt_input, filt_feedforward;
  logic [W-1:0] cp_out;
  lsr_sub_t filt_substitute [3];
  logic [31:0] shadow [5];
  int failures, samples_checked, i, c;
  lsr_top #(.W(W), .PW(PW)) dut_u (.clk(clk), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gen_trigger(gen_trigger), .gen_period(gen_period),
    .fe_setpoint(fe_setpoint), .fe_data(fe_data), .filt_out(filt_out),
    .cp_out(cp_out), .fe_trigger(fe_trigger), .dac_setpoint(dac_setpoint),
    .filt_input(filt_input), .filt_period(filt_period),
    .filt_feedforward(filt_feedforward), .filt_substitute(filt_substitute));
  lsr_far_model #(.W(W), .PW(PW)) far_u (.clk(clk), .rstn(rstn),
    .gen_trigger(gen_trigger), .gen_period(gen_period),
    .fe_setpoint(fe_setpoint), .fe_data(fe_data), .filt_out(filt_out),
    .cp_out(cp_out));
  // clock at 100 ns
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // expected setpoint of one dac
  function automatic logic [W-1:0] dac_exp(input int k, input logic [31:0] d);
    int s;
    s = d[8+8*k+:3];
    if (!d[k]) return fe_setpoint[k*W+:W];
    if (s == k || s == 7) return '0;
    if (s < 3) return fe_setpoint[s*W+:W];
    if (s == 3) return cp_out;
    return filt_out[(s-4)*W+:W];
  endfunction
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // compare every routed output against the shadow registers
  task automatic check_mux();
    logic [31:0] f, a, b;
    int k, s;
    f = shadow[2];
    a = shadow[3];
    b = shadow[4];
    repeat (2) begin
      @(negedge clk);
      for (k = 0; k < 3; k++) begin
        check("fe_trigger", fe_trigger[k],
              |(gen_trigger & shadow[0][4*k+:4]));
        check("dac_setpoint", dac_setpoint[k*W+:W],
              dac_exp(k, shadow[1]));
        s = f[2*k+:2];
        check("filt_input", filt_input[k*W+:W],
              s == 3 ? '0 : fe_data[s*W+:W]);
        s = f[8+2*k+:2];
        check("filt_period", filt_period[k*PW+:PW],
              gen_period[s*PW+:PW]);
        s = (k == 2) ? int'(f[18]) : (f[16+k] ? 2 : (k == 0 ? 1 : 0));
        check("filt_ffwd", filt_feedforward[k*W+:W],
              filt_out[s*W+:W]);
        s = f[24+2*k+:2];
        check("filt_sub", filt_substitute[k],
              s == 0 ? a[13:0] : s == 1 ? a[29:16] :
              s == 2 ? b[13:0] : 14'h0000);
      end
    end
  endtask
  // write, read back and recheck the routing
  task automatic wr(input int k, input logic [31:0] v);
    logic [31:0] rd;
    logic err;
    apb(1, OFS[k], v, rd, err);
    shadow[k] = v & MSK[k];
    apb(0, OFS[k], 32'h0000_0000, rd, err);
    check("readback", rd, shadow[k]);
    check("slverr", err, 0);
    check("pready", pready, 1);
    check_mux();
  endtask
  // every register back at its reset value, then the routing
  task automatic reset_check();
    logic [31:0] rd;
    logic err;
    for (int k = 0; k < 5; k++) begin
      shadow[k] = RST[k];
      apb(0, OFS[k], 32'h0000_0000, rd, err);
      check("reset value", rd, RST[k]);
    end
    check_mux();
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #(100 * 20000);
    failures++;
    end_sim();
  end
  // main sequence
  initial begin
    rstn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; failures = 0; samples_checked = 0;
    seed = 32'h2cb2_8aa5;
    for (i = 0; i < 5; i++) shadow[i] = RST[i];
    repeat (8) @(posedge clk);
    rstn <= 1;
    reset_check();
    apb(1, `LSR_OFS_SUBB + 4, 32'hffff_ffff, q, e);
    check("unmapped wr err", e, 1);
    apb(0, `LSR_OFS_TRIG - 4, 32'h0000_0000, q, e);
    check("unmapped rd err", e, 1);
    check("unmapped rd data", q, 0);
    for (i = 0; i < 5; i++) wr(i, 32'hffff_ffff);
    for (i = 0; i < 12; i++) wr(0, 32'h0000_0001 << i);
    for (c = 0; c < 8; c++)
      wr(1, {5'h00, 3'(c), 5'h00, 3'(c), 5'h00, 3'(c), 8'h07});
    for (c = 0; c < 4; c++)
      wr(2, {2'h0, {3{2'(c)}}, 5'h00, 3'(c + 5), 2'h0, {3{2'(c)}},
             2'h0, {3{2'(c)}}});
    for (i = 0; i < 40; i++) begin
      seed = xs(seed);
      c = seed % 5;
      seed = xs(seed);
      wr(c, seed);
    end
    // reset in mid-run: every register must return to its reset value
    @(posedge clk);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    reset_check();
    @(posedge clk);
    ce <= 0;
    apb(1, OFS[0], ~shadow[0], q, e);
    @(posedge clk);
    ce <= 1;
    apb(0, OFS[0], 32'h0000_0000, q, e);
    check("frozen write", q, shadow[0]);
    end_sim();
  end
endmodule // loop_signal_routing_mux_bench
